// File: logic/sas_horn.sv
// alarm horn pattern position counter
`default_nettype none
module sas_horn (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic run,
   input wire logic temporal,
   output logic pattern_on,
   output logic cycle_end,
   output logic [6:0] pos
);
   logic [6:0] last;
   logic tmp_on;

   assign last = temporal ? sas_pkg::SAS_TMP_LEN - 1'b1 : sas_pkg::SAS_CONT_LEN - 1'b1;
   // three pulses separated by gaps, then the long off to the end of the group
   assign tmp_on = (pos < sas_pkg::SAS_TMP_B1) ||
                   (pos >= sas_pkg::SAS_TMP_B2 && pos < sas_pkg::SAS_TMP_B3) ||
                   (pos >= sas_pkg::SAS_TMP_B4 && pos < sas_pkg::SAS_TMP_B5);
   assign pattern_on = temporal ? tmp_on : (pos < sas_pkg::SAS_CONT_ON);
   // >= covers a select change in the middle of a long group
   assign cycle_end = run && (pos >= last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= '0;
      end else if (!run) begin
         pos <= '0;
      end else if (tick) begin
         pos <= (pos >= last) ? 7'h00 : pos + 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: logic/sas_osc.sv
// oscillator period tick, test clock input and held-low detection
`default_nettype none
module sas_osc #(
   parameter logic [sas_pkg::SAS_CNT_W-1:0] STANDBY_CYCLES = sas_pkg::SAS_STANDBY_CYC,
   parameter logic [sas_pkg::SAS_CNT_W-1:0] ALARM_CYCLES = sas_pkg::SAS_ALARM_CYC,
   parameter logic [sas_pkg::SAS_CNT_W-1:0] HOLD_LOW_CYCLES = sas_pkg::SAS_HOLD_LOW_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fast,
   input wire logic ext_sel,
   input wire logic cap_pin,
   output logic tick,
   output logic held_low
);
   logic [sas_pkg::SAS_CNT_W-1:0] cnt;
   logic [sas_pkg::SAS_CNT_W-1:0] low_cnt;
   logic [sas_pkg::SAS_CNT_W-1:0] lim;
   logic pin_q;
   logic wrap;

   assign lim = fast ? ALARM_CYCLES : STANDBY_CYCLES;
   // >= lets a switch to the short period take effect at once
   assign wrap = (cnt >= lim - 1'b1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else if (wrap) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b1;
         tick <= 1'b0;
      end else begin
         pin_q <= cap_pin;
         tick <= ext_sel ? (cap_pin & ~pin_q) : wrap;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt <= '0;
         held_low <= 1'b0;
      end else if (cap_pin) begin
         low_cnt <= '0;
         held_low <= 1'b0;
      end else begin
         if (low_cnt < HOLD_LOW_CYCLES) begin
            low_cnt <= low_cnt + 1'b1;
         end
         held_low <= (low_cnt >= HOLD_LOW_CYCLES - 1'b1);
      end
   end
endmodule
`default_nettype wire

// File: logic/sas_pkg.sv
// constants, register map and types of the smoke alarm sequencer
`default_nettype none
package sas_pkg;
   // -----------------------------------------------------------------
   // clock and times
   // -----------------------------------------------------------------
   localparam int SAS_CLK_MHZ = 125;
   localparam int SAS_STANDBY_PERIOD_US = 1670000;
   localparam int SAS_ALARM_PERIOD_US = 41500;
   localparam int SAS_PULSE_US = 10500;
   // longer than half a 4 kHz test period, so a test clock never counts as held low
   localparam int SAS_HOLD_LOW_US = 1000;
   localparam int SAS_CNT_W = 28;
   localparam logic [SAS_CNT_W-1:0] SAS_STANDBY_CYC = SAS_CNT_W'(SAS_STANDBY_PERIOD_US * SAS_CLK_MHZ);
   localparam logic [SAS_CNT_W-1:0] SAS_ALARM_CYC = SAS_CNT_W'(SAS_ALARM_PERIOD_US * SAS_CLK_MHZ);
   localparam logic [SAS_CNT_W-1:0] SAS_PULSE_CYC = SAS_CNT_W'(SAS_PULSE_US * SAS_CLK_MHZ);
   localparam logic [SAS_CNT_W-1:0] SAS_HOLD_LOW_CYC = SAS_CNT_W'(SAS_HOLD_LOW_US * SAS_CLK_MHZ);
   // -----------------------------------------------------------------
   // schedule in oscillator periods
   // -----------------------------------------------------------------
   localparam logic [4:0] SAS_LED_PERIODS = 5'h18;
   localparam logic [4:0] SAS_LED_SLOT = 5'h00;
   localparam logic [4:0] SAS_CHIRP_SLOT = 5'h0c;
   localparam logic [6:0] SAS_CONT_ON = 7'h04;
   localparam logic [6:0] SAS_CONT_LEN = 7'h06;
   localparam logic [6:0] SAS_TMP_B1 = 7'h0c;
   localparam logic [6:0] SAS_TMP_B2 = 7'h18;
   localparam logic [6:0] SAS_TMP_B3 = 7'h24;
   localparam logic [6:0] SAS_TMP_B4 = 7'h30;
   localparam logic [6:0] SAS_TMP_B5 = 7'h3c;
   localparam logic [6:0] SAS_TMP_LEN = 7'h60;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int SAS_ADDR_W = 12;
   localparam logic [SAS_ADDR_W-1:0] SAS_CTRL_OFS = 12'h000;
   localparam logic [SAS_ADDR_W-1:0] SAS_STATUS_OFS = 12'h004;
   localparam logic [SAS_ADDR_W-1:0] SAS_SCHED_OFS = 12'h008;
   localparam logic SAS_CTRL_RST = 1'h0;
   localparam int SAS_CTRL_EXTCLK_BIT = 0;
   localparam int SAS_ST_ALARM_BIT = 0;
   localparam int SAS_ST_LOWBATT_BIT = 1;
   localparam int SAS_ST_PULSE_BIT = 2;
   localparam int SAS_ST_HORN_BIT = 3;
   localparam int SAS_ST_HELDLOW_BIT = 4;
   localparam int SAS_SCHED_SLOT_LSB = 0;
   localparam int SAS_SCHED_POS_LSB = 8;
   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic led;
      logic lb_test;
      logic chirp;
      logic smoke_ok;
   } sas_pulse_t;
   typedef enum logic [1:0] {
      SAS_PS_IDLE = 2'h0,
      SAS_PS_ON = 2'h1,
      SAS_PS_END = 2'h3
   } sas_pstate_t;
endpackage
`default_nettype wire

// File: logic/sas_top.sv
// smoke alarm sequencer: schedule, strobe pulse, latches, outputs and APB registers
`default_nettype none
module sas_top #(
   parameter logic [sas_pkg::SAS_CNT_W-1:0] STANDBY_CYCLES = sas_pkg::SAS_STANDBY_CYC,
   parameter logic [sas_pkg::SAS_CNT_W-1:0] ALARM_CYCLES = sas_pkg::SAS_ALARM_CYC,
   parameter logic [sas_pkg::SAS_CNT_W-1:0] PULSE_CYCLES = sas_pkg::SAS_PULSE_CYC,
   parameter logic [sas_pkg::SAS_CNT_W-1:0] HOLD_LOW_CYCLES = sas_pkg::SAS_HOLD_LOW_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sas_pkg::SAS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_timing_cap_pin,
   input wire logic horn_pattern_sel,
   input wire logic smoke_comp_in,
   input wire logic low_batt_comp_in,
   output logic detect_power,
   output logic led_drive,
   output logic horn_drive,
   output logic hysteresis_en,
   output logic smoke_setpoint_isolate
);
   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic ext_clk_sel;
   logic tick;
   logic tick_q;
   logic held_low;
   logic alarm;
   logic low_batt;
   logic [4:0] slot;
   logic pattern_on;
   logic cycle_end;
   logic [6:0] horn_pos;
   sas_pkg::sas_pstate_t pstate;
   sas_pkg::sas_pstate_t next_pstate;
   sas_pkg::sas_pulse_t flags;
   sas_pkg::sas_pulse_t next_flags;
   logic [sas_pkg::SAS_CNT_W-1:0] pulse_cnt;
   logic pulse_on;
   logic pulse_last;
   logic launch;
   logic setup;
   logic access;
   logic [31:0] rd_word;
   logic rd_err;

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   function automatic logic reg_hit(input logic [sas_pkg::SAS_ADDR_W-1:0] a,
                                    input logic [sas_pkg::SAS_ADDR_W-1:0] ofs);
      reg_hit = (a == ofs);
   endfunction

   function automatic logic mapped(input logic [sas_pkg::SAS_ADDR_W-1:0] a);
      mapped = reg_hit(a, sas_pkg::SAS_CTRL_OFS) ||
               reg_hit(a, sas_pkg::SAS_STATUS_OFS) ||
               reg_hit(a, sas_pkg::SAS_SCHED_OFS);
   endfunction

   // -----------------------------------------------------------------
   // oscillator and horn pattern
   // -----------------------------------------------------------------
   sas_osc #(
      .STANDBY_CYCLES(STANDBY_CYCLES),
      .ALARM_CYCLES(ALARM_CYCLES),
      .HOLD_LOW_CYCLES(HOLD_LOW_CYCLES)
   ) i_sas_osc (
      .pclk(pclk),
      .presetn(presetn),
      .fast(alarm),
      .ext_sel(ext_clk_sel),
      .cap_pin(osc_timing_cap_pin),
      .tick(tick),
      .held_low(held_low)
   );

   sas_horn i_sas_horn (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .run(alarm),
      .temporal(horn_pattern_sel),
      .pattern_on(pattern_on),
      .cycle_end(cycle_end),
      .pos(horn_pos)
   );

   // -----------------------------------------------------------------
   // period schedule
   // -----------------------------------------------------------------
   // the same slot count gives 40 s in standby and about 1 s in alarm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot <= '0;
      end else if (tick) begin
         slot <= (slot >= sas_pkg::SAS_LED_PERIODS - 1'b1) ? 5'h00 : slot + 1'b1;
      end
   end

   // pulse starts one cycle after the tick so slot and horn position are already updated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= tick;
      end
   end

   // -----------------------------------------------------------------
   // strobe pulse sequencer
   // -----------------------------------------------------------------
   assign pulse_on = (pstate == sas_pkg::SAS_PS_ON);
   assign pulse_last = pulse_on && (pulse_cnt <= 1);
   // a tick that lands inside a running pulse only advances the counters
   assign launch = tick_q && (pstate == sas_pkg::SAS_PS_IDLE);

   always_comb begin
      next_flags.led = (slot == sas_pkg::SAS_LED_SLOT);
      next_flags.lb_test = next_flags.led && !alarm;
      next_flags.chirp = (slot == sas_pkg::SAS_CHIRP_SLOT) && low_batt && !alarm;
      // alarm sampling waits for the final off period of the horn cycle
      next_flags.smoke_ok = !next_flags.lb_test && !next_flags.chirp &&
                            (!alarm || cycle_end);
   end

   always_comb begin
      next_pstate = pstate;
      case (pstate)
         sas_pkg::SAS_PS_IDLE: begin
            if (launch) begin
               next_pstate = sas_pkg::SAS_PS_ON;
            end
         end
         sas_pkg::SAS_PS_ON: begin
            if (pulse_last) begin
               next_pstate = sas_pkg::SAS_PS_END;
            end
         end
         sas_pkg::SAS_PS_END: begin
            next_pstate = sas_pkg::SAS_PS_IDLE;
         end
         default: begin
            next_pstate = sas_pkg::SAS_PS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pstate <= sas_pkg::SAS_PS_IDLE;
      end else begin
         pstate <= next_pstate;
      end
   end

   // width is counted in pclk cycles, so a fast test clock keeps the full strobe width
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt <= '0;
         flags <= '0;
      end else if (launch) begin
         pulse_cnt <= PULSE_CYCLES;
         flags <= next_flags;
      end else if (pulse_on && pulse_cnt != 0) begin
         pulse_cnt <= pulse_cnt - 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // comparator latches
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm <= 1'b0;
      end else if (pulse_last && flags.smoke_ok) begin
         alarm <= smoke_comp_in;
      end
   end

   // sampled in the last cycle of the LED pulse, while the battery still carries the load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_batt <= 1'b0;
      end else if (pulse_last && flags.lb_test) begin
         low_batt <= low_batt_comp_in;
      end
   end

   // -----------------------------------------------------------------
   // driver outputs
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         detect_power <= 1'b0;
         led_drive <= 1'b0;
         horn_drive <= 1'b0;
         hysteresis_en <= 1'b0;
         smoke_setpoint_isolate <= 1'b0;
      end else begin
         detect_power <= (next_pstate == sas_pkg::SAS_PS_ON) || held_low;
         led_drive <= (next_pstate == sas_pkg::SAS_PS_ON) &&
                      (launch ? next_flags.led : flags.led);
         smoke_setpoint_isolate <= (next_pstate == sas_pkg::SAS_PS_ON) &&
                                   (launch ? next_flags.lb_test : flags.lb_test);
         if (alarm) begin
            horn_drive <= pattern_on;
         end else begin
            horn_drive <= (next_pstate == sas_pkg::SAS_PS_ON) &&
                          (launch ? next_flags.chirp : flags.chirp);
         end
         hysteresis_en <= alarm;
      end
   end

   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   // zero wait states: every access phase completes in its first cycle
   assign pready = 1'b1;
   assign setup = psel && !penable;
   assign access = psel && penable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_clk_sel <= sas_pkg::SAS_CTRL_RST;
      end else if (access && pwrite && reg_hit(paddr, sas_pkg::SAS_CTRL_OFS)) begin
         ext_clk_sel <= pwdata[sas_pkg::SAS_CTRL_EXTCLK_BIT];
      end
   end

   always_comb begin
      rd_word = '0;
      if (reg_hit(paddr, sas_pkg::SAS_CTRL_OFS)) begin
         rd_word[sas_pkg::SAS_CTRL_EXTCLK_BIT] = ext_clk_sel;
      end else if (reg_hit(paddr, sas_pkg::SAS_STATUS_OFS)) begin
         rd_word[sas_pkg::SAS_ST_ALARM_BIT] = alarm;
         rd_word[sas_pkg::SAS_ST_LOWBATT_BIT] = low_batt;
         rd_word[sas_pkg::SAS_ST_PULSE_BIT] = pulse_on;
         rd_word[sas_pkg::SAS_ST_HORN_BIT] = horn_drive;
         rd_word[sas_pkg::SAS_ST_HELDLOW_BIT] = held_low;
      end else if (reg_hit(paddr, sas_pkg::SAS_SCHED_OFS)) begin
         rd_word[sas_pkg::SAS_SCHED_SLOT_LSB +: 5] = slot;
         rd_word[sas_pkg::SAS_SCHED_POS_LSB +: 7] = horn_pos;
      end
   end

   // read data and error are captured in the setup cycle and held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         rd_err <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
         rd_err <= !mapped(paddr);
      end
   end

   assign pslverr = access && rd_err;
endmodule
`default_nettype wire

// File: tb/sas_checker.sv
// port assertions for the smoke alarm sequencer
`default_nettype none
module sas_checker #(
   parameter logic [sas_pkg::SAS_CNT_W-1:0] STANDBY_CYCLES = sas_pkg::SAS_STANDBY_CYC,
   parameter logic [sas_pkg::SAS_CNT_W-1:0] ALARM_CYCLES = sas_pkg::SAS_ALARM_CYC,
   parameter logic [sas_pkg::SAS_CNT_W-1:0] HOLD_LOW_CYCLES = sas_pkg::SAS_HOLD_LOW_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sas_pkg::SAS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic osc_timing_cap_pin,
   input wire logic horn_pattern_sel,
   input wire logic detect_power,
   input wire logic led_drive,
   input wire logic horn_drive,
   input wire logic hysteresis_en,
   input wire logic smoke_setpoint_isolate
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AP = int'(ALARM_CYCLES);
   localparam int SP = int'(STANDBY_CYCLES);
   localparam int HL = int'(HOLD_LOW_CYCLES);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   int low_len, on_len, off_len, led_gap;
   logic led_q, fell_al, on_ok, off_ok, led_al, led_sb, ext_q;
   logic ctrl_wr;
   assign ctrl_wr = psel && penable && pwrite && paddr == sas_pkg::SAS_CTRL_OFS;
   // gap checks are trusted only when both ends of the gap lie in one mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_len <= 0;
         on_len <= 0;
         off_len <= 0;
         led_gap <= 0;
         led_q <= 1'b0;
         fell_al <= 1'b0;
         on_ok <= 1'b0;
         off_ok <= 1'b0;
         led_al <= 1'b0;
         led_sb <= 1'b0;
         ext_q <= 1'b0;
      end else begin
         low_len <= osc_timing_cap_pin ? 0 : low_len + 1;
         on_len <= horn_drive ? on_len + 1 : 0;
         off_len <= horn_drive ? 0 : off_len + 1;
         led_q <= led_drive;
         led_gap <= (led_drive && !led_q) ? 1 : led_gap + 1;
         ext_q <= ctrl_wr ? pwdata[0] : ext_q;
         // edges from standby chirps or an earlier alarm must not qualify a new alarm's timing
         if (!hysteresis_en) begin
            fell_al <= 1'b0;
            on_ok <= 1'b0;
            off_ok <= 1'b0;
         end else begin
            if ($fell(horn_drive)) begin
               fell_al <= 1'b1;
               off_ok <= 1'b1;
            end
            if ($rose(horn_drive)) begin
               on_ok <= fell_al;
            end
         end
         if (ctrl_wr) begin
            led_al <= 1'b0;
            led_sb <= 1'b0;
         end else if (led_drive && !led_q) begin
            led_al <= hysteresis_en;
            led_sb <= !hysteresis_en;
         end else begin
            led_al <= led_al && hysteresis_en;
            led_sb <= led_sb && !hysteresis_en;
         end
      end
   end
   chk_reset_quiet: assert property ($rose(presetn) |-> !(led_drive || horn_drive || hysteresis_en || detect_power))
      else $error("output active right after reset");
   chk_led_width: assert property ($rose(led_drive) |-> led_drive[*8] ##[1:6] !led_drive)
      else $error("led pulse width wrong");
   chk_strobe_width: assert property ($rose(detect_power) && low_len == 0 |-> ##[8:14] (!detect_power || low_len > 0))
      else $error("strobe pulse too long");
   chk_hold_strobe: assert property (low_len > HL + 3 |-> detect_power)
      else $error("strobe not held with pin low");
   chk_iso_test: assert property (smoke_setpoint_isolate |-> led_drive && !hysteresis_en)
      else $error("isolation outside battery test");
   chk_chirp_short: assert property ($fell(horn_drive) && !hysteresis_en |-> on_len < 14)
      else $error("chirp too long");
   chk_cont_on: assert property ($fell(horn_drive) && hysteresis_en && on_ok && !horn_pattern_sel |->
      on_len inside {[4*AP-4:4*AP+4]}) else $error("continuous on time wrong");
   chk_cont_off: assert property ($rose(horn_drive) && hysteresis_en && off_ok && !horn_pattern_sel |->
      off_len inside {[2*AP-4:2*AP+4]}) else $error("continuous off time wrong");
   chk_tmp_on: assert property ($fell(horn_drive) && hysteresis_en && on_ok && horn_pattern_sel |->
      on_len inside {[12*AP-4:12*AP+4]}) else $error("temporal on time wrong");
   chk_tmp_off: assert property ($rose(horn_drive) && hysteresis_en && off_ok && horn_pattern_sel |->
      off_len inside {[12*AP-4:12*AP+4], [36*AP-4:36*AP+4]}) else $error("temporal off time wrong");
   chk_led_alarm: assert property ($rose(led_drive) && led_al && hysteresis_en && !ext_q |->
      led_gap inside {[24*AP-3:24*AP+3]}) else $error("alarm led spacing wrong");
   chk_led_standby: assert property ($rose(led_drive) && led_sb && !hysteresis_en && !ext_q |->
      led_gap inside {[24*SP-3:24*SP+3]}) else $error("standby led spacing wrong");
   cover property ($rose(hysteresis_en));
   cover property ($fell(horn_drive) && !hysteresis_en);
   cover property (smoke_setpoint_isolate);
   cover property ($rose(led_drive) && ext_q);
endmodule
bind sas_top sas_checker #(.STANDBY_CYCLES(STANDBY_CYCLES), .ALARM_CYCLES(ALARM_CYCLES),
   .HOLD_LOW_CYCLES(HOLD_LOW_CYCLES)) i_sas_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .osc_timing_cap_pin(osc_timing_cap_pin),
   .horn_pattern_sel(horn_pattern_sel), .detect_power(detect_power), .led_drive(led_drive),
   .horn_drive(horn_drive), .hysteresis_en(hysteresis_en), .smoke_setpoint_isolate(smoke_setpoint_isolate));
`default_nettype wire

// File: tb/sas_far.sv
// comparator model on the far side of the sequencer
`default_nettype none
module sas_far (
   input wire logic pclk,
   input wire logic detect_power,
   input wire logic led_drive,
   input wire logic smoke_level,
   input wire logic batt_low,
   output logic smoke_comp_in,
   output logic low_batt_comp_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic junk = 1'b0;
   // unpowered comparators give no valid answer, so show a changing level
   always @(posedge pclk) junk <= ~junk;
   assign smoke_comp_in = detect_power ? smoke_level : junk;
   assign low_batt_comp_in = led_drive ? batt_low : ~junk;
endmodule
`default_nettype wire

// File: tb/test_smoke_alarm_sequencer.sv
// self-checking testbench of the smoke alarm sequencer
`default_nettype none
module test_smoke_alarm_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cap, sel, smoke_level, batt_low;
   logic smoke_comp_in, low_batt_comp_in, detect_power, led_drive, horn_drive, hysteresis_en, iso;
   logic [sas_pkg::SAS_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [31:0] rng = 32'h00000040;
   logic [32:0] exp_q[$];
   int fails, check_count;
   sas_top #(.STANDBY_CYCLES(28'h00000c8), .ALARM_CYCLES(28'h000003c), .PULSE_CYCLES(28'h000000a),
      .HOLD_LOW_CYCLES(28'h0000014)) i_sas_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_timing_cap_pin(cap), .horn_pattern_sel(sel), .smoke_comp_in(smoke_comp_in),
      .low_batt_comp_in(low_batt_comp_in), .detect_power(detect_power), .led_drive(led_drive),
      .horn_drive(horn_drive), .hysteresis_en(hysteresis_en), .smoke_setpoint_isolate(iso));
   sas_far i_sas_far (.pclk(pclk), .detect_power(detect_power), .led_drive(led_drive), .smoke_level(smoke_level),
      .batt_low(batt_low), .smoke_comp_in(smoke_comp_in), .low_batt_comp_in(low_batt_comp_in));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic sig(input int w);
      case (w)
         0: return led_drive;
         1: return horn_drive;
         2: return hysteresis_en;
         default: return detect_power;
      endcase
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic xfer(input logic w, input logic [sas_pkg::SAS_ADDR_W-1:0] a, input logic [31:0] dv);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (i >= 16) check("pready", 33'h0, 33'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [sas_pkg::SAS_ADDR_W-1:0] a, input logic [32:0] exp);
      exp_q.push_back(exp);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic wait_for(input int w, input logic lvl, input int lim);
      int i;
      i = 0;
      while (sig(w) !== lvl && i < lim) begin
         @(posedge pclk);
         i++;
      end
      if (i >= lim) begin
         check("wait", 33'(w), 33'h1ffffffff);
         stop_test();
      end
   endtask
   // reads are compared when the access phase completes
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) check("read", {pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 'x);
   end
   initial begin
      repeat (80000) @(posedge pclk);
      check("run length", 33'h0, 33'h1);
      stop_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, smoke_level, batt_low} = 6'h00;
      {cap, sel} = 2'h3;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(sas_pkg::SAS_CTRL_OFS, 33'h0);
      rd(sas_pkg::SAS_STATUS_OFS, 33'h0);
      rd(12'h00c, 33'h100000000);
      xfer(1'b1, sas_pkg::SAS_STATUS_OFS, 32'hffffffff);
      rd(sas_pkg::SAS_STATUS_OFS, 33'h0);
      repeat (3) begin
         d = xs();
         xfer(1'b1, sas_pkg::SAS_CTRL_OFS, d);
         rd(sas_pkg::SAS_CTRL_OFS, {32'h0, d[0]});
      end
      xfer(1'b1, sas_pkg::SAS_CTRL_OFS, 32'h0);
      $display("registers done");
      batt_low <= 1'b1;
      wait_for(0, 1'b1, 5200);
      check("isolate", {32'h0, iso}, 33'h1);
      wait_for(0, 1'b0, 20);
      repeat (3) @(posedge pclk);
      rd(sas_pkg::SAS_STATUS_OFS, 33'h2);
      wait_for(1, 1'b1, 2600);
      check("chirp alarm", {32'h0, hysteresis_en}, 33'h0);
      wait_for(1, 1'b0, 16);
      // a second standby led gives the spacing check a full standby gap
      wait_for(0, 1'b1, 2600);
      wait_for(0, 1'b0, 20);
      $display("battery done");
      smoke_level <= 1'b1;
      wait_for(2, 1'b1, 500);
      repeat (4) begin
         wait_for(1, 1'b1, 2300);
         wait_for(1, 1'b0, 800);
      end
      smoke_level <= 1'b0;
      wait_for(2, 1'b0, 6200);
      check("horn at exit", {32'h0, horn_drive}, 33'h0);
      repeat (3) @(posedge pclk);
      rd(sas_pkg::SAS_STATUS_OFS, 33'h2);
      $display("temporal done");
      sel <= 1'b0;
      smoke_level <= 1'b1;
      wait_for(2, 1'b1, 500);
      repeat (3) begin
         wait_for(1, 1'b1, 400);
         wait_for(1, 1'b0, 300);
      end
      presetn <= 1'b0;
      smoke_level <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(sas_pkg::SAS_STATUS_OFS, 33'h0);
      $display("continuous done");
      cap <= 1'b0;
      wait_for(3, 1'b1, 40);
      repeat (4) @(posedge pclk);
      check("held strobe", {32'h0, detect_power}, 33'h1);
      rd(sas_pkg::SAS_STATUS_OFS, 33'h10);
      cap <= 1'b1;
      xfer(1'b1, sas_pkg::SAS_CTRL_OFS, 32'h1);
      fork
         repeat (120) begin
            repeat (8) @(posedge pclk);
            cap <= ~cap;
         end
      join_none
      wait_for(0, 1'b1, 800);
      wait fork;
      xfer(1'b1, sas_pkg::SAS_CTRL_OFS, 32'h0);
      $display("test clock done");
      stop_test();
   end
endmodule
`default_nettype wire
